//--- sac_pkg.sv
// Shared constants for the successive-approximation conversion control block
package sac_pkg;
	localparam int SAC_BITS = 10;
	localparam int SAC_CLK_MHZ = 20;
	localparam int SAC_CONV_MIN_NS = 15000;
	localparam int SAC_CONV_TYP_NS = 25000;
	localparam int SAC_CONV_MAX_NS = 40000;
	localparam int SAC_DATA_VALID_NS = 500;
	localparam int SAC_RELEASE_NS = 1500;
	localparam int SAC_BLANK_MIN_NS = 2000;
	// Cycle counts: least times round up, longest times round down
	localparam int SAC_CONV_CYC = (SAC_CONV_TYP_NS * SAC_CLK_MHZ + 999) / 1000;
	localparam int SAC_CONV_MIN_CYC = (SAC_CONV_MIN_NS * SAC_CLK_MHZ + 999) / 1000;
	localparam int SAC_CONV_MAX_CYC = (SAC_CONV_MAX_NS * SAC_CLK_MHZ) / 1000;
	localparam int SAC_BIT_CYC = SAC_CONV_CYC / SAC_BITS;
	localparam int SAC_RELEASE_CYC = (SAC_RELEASE_NS * SAC_CLK_MHZ) / 1000;
	localparam int SAC_BLANK_CYC = (SAC_BLANK_MIN_NS * SAC_CLK_MHZ + 999) / 1000;
	localparam int SAC_DATA_VALID_CYC = (SAC_DATA_VALID_NS * SAC_CLK_MHZ) / 1000;
	localparam logic [9:0] SAC_CODE_ZERO = 10'h000;
	localparam logic [9:0] SAC_MSB_ONE = 10'h200;
	// Bipolar offset in input units: one MSB less half an LSB, held at twice scale
	localparam logic [11:0] SAC_BIP_OFFSET_X2 = 12'h3FF;
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_CONV = 2'b01,
		SAC_DONE = 2'b11,
		SAC_HALT = 2'b10
	} sac_state_e;
endpackage : sac_pkg

//--- sac_bit_timer.sv
// Divider that produces one enable pulse per tested bit
`timescale 1ns/1ns
module sac_bit_timer
	import sac_pkg::*;
#(
	parameter int PERIOD = SAC_BIT_CYC
)(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic run,
	output logic tick
);
	logic [7:0] cnt_q;
	wire last_w = (cnt_q == 8'(PERIOD - 1));
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b || !run)
			cnt_q <= 8'h00;
		else if (last_w)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
	end
	assign tick = run && last_w;
endmodule : sac_bit_timer

//--- sac_conv_ctrl.sv
// Successive-approximation conversion control with blank/convert line and three-state data
// How it works
// R1: A conversion tests the 10 result bits one at a time from the top bit down to bit 0.
// R2: A trial bit stays set when the trial value is below the input and is cleared when above.
// R3: After the last bit the approximation register holds the full code shown on the data pins.
// R4: When the bit sequence ends the active-low done flag is driven low.
// R5: The done flag going low enables the data drivers, which then show the stored bits.
// R6: Raising the blank/convert line floats the data pins and re-arms the register.
// R7: With the offset input tied low the input range is unipolar and the code straight binary.
// R8: With the offset input open an offset is added so the range is bipolar, offset-binary code.
// R9: In bipolar coding the lowest input gives all zeros and the highest all ones; here an analog_in of 0 gives 10'h1FF.
// R10: In unipolar coding the top transition lies one LSB below full scale.
// R11: A conversion takes between 15 and 40 microseconds, typically 25.
// R12: Pulling the line low starts a conversion; flag and data stay unchanged until it ends.
// R13: Data is valid on the pins within 500 ns of the flag falling.
// R14: About 1.5 us after the line rises the flag goes high and the data floats.
// R15: A high pulse of at least 2 us blanks old data, and during a conversion restarts it.
// R16: The controller keeps the line low and waits for the flag before reading data.
`timescale 1ns/1ns
module sac_conv_ctrl
	import sac_pkg::*;
#(
	parameter int BITS = SAC_BITS,
	parameter int RELEASE_CYC = SAC_RELEASE_CYC,
	parameter int BLANK_CYC = SAC_BLANK_CYC
)(
	// Clock and synchronous reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Controller line: low converts, high blanks
	input wire logic blank_convert_n,
	// Offset select and input level
	input wire logic bipolar_open,
	input wire logic [BITS:0] analog_in,
	// Open-drain done flag
	output logic conversion_done_n_o,
	output logic conversion_done_n_oe_b,
	// Three-state result bus, enables active low
	output logic [BITS-1:0] data_o,
	output logic [BITS-1:0] data_oe_b,
	// Trial code fed to the converter
	output logic [BITS-1:0] dac_code
);
	// analog_in is the input sampled at twice LSB scale, so half-LSB offsets are exact
	sac_state_e state_q, state_d;
	logic [1:0] bc_sync_q;
	logic [1:0] bip_sync_q;
	// The input word is a slow level; two stages keep a changing word off the comparator
	logic [BITS:0] ain_meta_q;
	logic [BITS:0] ain_q;
	logic [BITS-1:0] sar_q, sar_d;
	logic [BITS-1:0] trial_q, trial_d;
	logic [5:0] high_cnt_q;
	logic [5:0] high_cnt_d;
	logic done_n_q, done_n_d;
	logic [BITS-1:0] data_q;
	logic [BITS-1:0] oe_b_q;
	logic [BITS-1:0] dac_q;
	logic tick;

	// Synchronised pin levels
	wire line_high_w = bc_sync_q[1];
	wire line_low_w = !bc_sync_q[1];
	wire bipolar_w = bip_sync_q[1];

	// High time saturates, so that both the release and the blank limit are reached
	wire high_sat_w = (high_cnt_q == 6'h3F);
	wire [5:0] high_inc_w = high_cnt_q + 6'h01;
	wire released_w = (high_cnt_q >= 6'(RELEASE_CYC));
	wire blanked_w = (high_cnt_q >= 6'(BLANK_CYC));

	// Sequencer events
	wire running_w = (state_q == SAC_CONV);
	wire armed_w = (state_q == SAC_IDLE) || (state_q == SAC_HALT);
	wire start_w = armed_w && line_low_w;
	wire timer_run_w = running_w && line_low_w;
	wire step_w = timer_run_w && tick;
	wire abort_w = running_w && line_high_w && blanked_w;
	wire release_w = (state_q == SAC_DONE) && line_high_w && released_w;
	wire last_bit_w = trial_q[0];
	wire [BITS-1:0] trial_code_w = sar_q | trial_q;

	// Comparator: trial DAC value against input, with optional bipolar offset injection
	function automatic logic trial_below(input logic [BITS-1:0] code,
		input logic [BITS:0] ain, input logic bip);
		logic [BITS+1:0] lhs;
		lhs = {1'b0, code, 1'b0};
		if (bip) // R8
			return (lhs <= ({1'b0, ain} + 12'(SAC_BIP_OFFSET_X2))); // R9
		return (lhs <= {1'b0, ain}); // R7 R10
	endfunction : trial_below

	wire keep_bit_w = trial_below(trial_code_w, ain_q, bipolar_w);

	sac_bit_timer #(
		.PERIOD(SAC_BIT_CYC) // R11
	) u_timer (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.run(timer_run_w),
		.tick(tick)
	);

	// Next-state logic for the sequencer and the approximation register
	always_comb
	begin
		state_d = state_q;
		sar_d = sar_q;
		trial_d = trial_q;
		done_n_d = done_n_q;
		unique case (state_q)
			SAC_IDLE:
			begin
				if (start_w) // R12
				begin
					state_d = SAC_CONV;
					sar_d = SAC_CODE_ZERO;
					trial_d = SAC_MSB_ONE; // R1
				end
			end
			SAC_CONV:
			begin
				// A short high pulse only clears the bit timer count
				if (abort_w) // R15
					state_d = SAC_IDLE;
				else if (step_w)
				begin
					if (keep_bit_w) // R2
						sar_d = trial_code_w;
					trial_d = trial_q >> 1; // R1
					if (last_bit_w)
					begin
						state_d = SAC_DONE; // R3
						done_n_d = 1'b0; // R4
					end
				end
			end
			SAC_DONE:
			begin
				// Flag and data stand until the line has been high for the release time
				if (release_w) // R14
				begin
					done_n_d = 1'b1;
					state_d = SAC_HALT; // R6
				end
			end
			SAC_HALT:
			begin
				if (start_w) // R12
				begin
					state_d = SAC_CONV;
					sar_d = SAC_CODE_ZERO; // R6
					trial_d = SAC_MSB_ONE;
				end
			end
		endcase
	end

	// High-time counter for the release and blank limits
	always_comb
	begin
		high_cnt_d = 6'h00;
		if (line_high_w)
			high_cnt_d = high_sat_w ? high_cnt_q : high_inc_w; // R14 R15
	end

	// Pin synchronisers: only the second stage is read by the logic
	always_ff @(posedge clk_sys)
	begin
		bc_sync_q <= {bc_sync_q[0], blank_convert_n};
		bip_sync_q <= {bip_sync_q[0], bipolar_open};
		ain_meta_q <= analog_in;
		ain_q <= ain_meta_q;
	end

	// Sequencer state and approximation register
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			state_q <= SAC_IDLE;
			sar_q <= SAC_CODE_ZERO;
			trial_q <= SAC_CODE_ZERO;
			high_cnt_q <= 6'h00;
			done_n_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			sar_q <= sar_d;
			trial_q <= trial_d;
			high_cnt_q <= high_cnt_d;
			done_n_q <= done_n_d;
		end
	end

	// Output registers follow the next state, so flag, drivers and data change on one edge
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			data_q <= SAC_CODE_ZERO;
			oe_b_q <= '1;
			dac_q <= SAC_CODE_ZERO;
		end
		else
		begin
			data_q <= sar_d; // R3 R13
			oe_b_q <= {BITS{done_n_d}}; // R5 R6
			dac_q <= sar_d | trial_d;
		end
	end

	// Flag level is fixed low; the enable alone carries the flag
	assign conversion_done_n_o = 1'b0;
	assign conversion_done_n_oe_b = done_n_q; // R4
	assign data_o = data_q;
	assign data_oe_b = oe_b_q;
	assign dac_code = dac_q;
endmodule : sac_conv_ctrl

//--- sac_conv_ctrl_properties.sv
// Port assertions for the conversion control block
`timescale 1ns/1ns
module sac_conv_ctrl_props
	import sac_pkg::*;
#(
	parameter int BITS = SAC_BITS
)(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic blank_convert_n,
	input wire logic conversion_done_n_o,
	input wire logic conversion_done_n_oe_b,
	input wire logic [BITS-1:0] data_o,
	input wire logic [BITS-1:0] data_oe_b,
	input wire logic [BITS-1:0] dac_code
);
	logic [11:0] low_q;
	// Cycles the line spent low since the last result
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b || !conversion_done_n_oe_b)
			low_q <= 12'h000;
		else if (!blank_convert_n)
			low_q <= low_q + 12'h001;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	data_float_a: assert property (data_oe_b == {BITS{conversion_done_n_oe_b}})
		else $error("data drive differs from flag");
	result_show_a: assert property ($fell(conversion_done_n_oe_b) |-> data_o == dac_code)
		else $error("result differs from register");
	result_hold_a: assert property (!conversion_done_n_oe_b && !$past(conversion_done_n_oe_b)
		|-> $stable(data_o)) else $error("data changed while shown");
	flag_drive_a: assert property (conversion_done_n_o == 1'b0)
		else $error("flag drives high");
	conv_time_a: assert property ($fell(conversion_done_n_oe_b) |-> low_q inside {[300:800]})
		else $error("conversion time out of range");
	msb_first_a: assert property ($changed(dac_code) && $past(dac_code) == 10'h000
		|-> dac_code == SAC_MSB_ONE) else $error("first trial not top bit");
	flag_release_a: assert property (!conversion_done_n_oe_b && blank_convert_n
		|-> ##[1:40] (conversion_done_n_oe_b || !blank_convert_n)) else $error("no release");
	flag_stand_a: assert property ($rose(conversion_done_n_oe_b) |-> $past(blank_convert_n, 8))
		else $error("flag released early");
endmodule : sac_conv_ctrl_props
bind sac_conv_ctrl sac_conv_ctrl_props #(.BITS(BITS)) sac_conv_ctrl_props_i (.clk_sys(clk_sys),
	.rst_b(rst_b), .blank_convert_n(blank_convert_n), .conversion_done_n_o(conversion_done_n_o),
	.conversion_done_n_oe_b(conversion_done_n_oe_b), .data_o(data_o), .data_oe_b(data_oe_b),
	.dac_code(dac_code));

//--- sac_ctrl_model.sv
// Controller model that drives the blank/convert line and reads results
`timescale 1ns/1ns
module sac_ctrl_model
	import sac_pkg::*;
(
	input wire logic clk_sys,
	input wire logic conversion_done_n_oe_b,
	input wire logic [SAC_BITS-1:0] data_o,
	input wire logic [SAC_BITS-1:0] data_oe_b,
	output logic blank_convert_n
);
	// Floated lines read as the inverse so stale data never matches
	wire logic [SAC_BITS-1:0] bus = data_oe_b == '0 ? data_o : ~data_o;
	initial blank_convert_n = 1'b1;
	task automatic convert(output logic [SAC_BITS-1:0] code, output int took);
		took = 0;
		@(posedge clk_sys) blank_convert_n <= 1'b0;
		while (conversion_done_n_oe_b !== 1'b0 && took < 900)
		begin
			@(posedge clk_sys);
			took++;
		end
		code = bus;
		@(posedge clk_sys) blank_convert_n <= 1'b1;
		repeat (SAC_BLANK_CYC + 4) @(posedge clk_sys);
	endtask : convert
	task automatic blank(input int low);
		@(posedge clk_sys) blank_convert_n <= 1'b0;
		repeat (low) @(posedge clk_sys);
		blank_convert_n <= 1'b1;
		repeat (SAC_BLANK_CYC + 5) @(posedge clk_sys);
	endtask : blank
endmodule : sac_ctrl_model

//--- test_sar_adc_conversion_control.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ns
module test_sar_adc_conversion_control
	import sac_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic bipolar_open = 1'b0;
	logic [SAC_BITS:0] analog_in = '0;
	logic blank_convert_n, conversion_done_n_o, conversion_done_n_oe_b;
	logic [SAC_BITS-1:0] data_o, data_oe_b, dac_code, code;
	int n_fail = 0;
	int n_compared = 0;
	int took;
	always #25 clk_sys = ~clk_sys;
	sac_conv_ctrl sac_conv_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.blank_convert_n(blank_convert_n), .bipolar_open(bipolar_open), .analog_in(analog_in),
		.conversion_done_n_o(conversion_done_n_o), .conversion_done_n_oe_b(conversion_done_n_oe_b),
		.data_o(data_o), .data_oe_b(data_oe_b), .dac_code(dac_code));
	sac_ctrl_model sac_ctrl_model_i (.clk_sys(clk_sys), .conversion_done_n_oe_b(conversion_done_n_oe_b),
		.data_o(data_o), .data_oe_b(data_oe_b), .blank_convert_n(blank_convert_n));
	task automatic check(input string what, input logic [SAC_BITS-1:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic conv_one(input logic [SAC_BITS:0] ain, input logic bip, output logic [9:0] got);
		@(posedge clk_sys);
		analog_in <= ain;
		bipolar_open <= bip;
		repeat (4) @(posedge clk_sys);
		sac_ctrl_model_i.convert(got, took);
		if (took >= 900)
		begin
			n_fail++;
			wrap_up();
		end
		check("float", data_oe_b, 10'h3FF);
	endtask : conv_one
	task automatic test_unipolar;
		conv_one(11'h000, 1'b0, code);
		check("zero", code, 10'h000);
		conv_one(11'h555, 1'b0, code);
		check("mid", code, 10'h2AA);
		conv_one(11'h7FD, 1'b0, code);
		check("below top", code, 10'h3FE);
		conv_one(11'h7FE, 1'b0, code);
		check("top", code, 10'h3FF);
		$display("unipolar done");
	endtask : test_unipolar
	task automatic test_bipolar;
		conv_one(11'h7FF, 1'b1, code);
		check("bip top", code, 10'h3FF);
		conv_one(11'h001, 1'b1, code);
		check("bip mid", code, 10'h200);
		$display("bipolar done");
	endtask : test_bipolar
	task automatic test_abort;
		@(posedge clk_sys) analog_in <= 11'h3FF;
		sac_ctrl_model_i.blank(100);
		check("no flag", {9'h000, conversion_done_n_oe_b}, 10'h001);
		conv_one(11'h100, 1'b0, code);
		check("restart", code, 10'h080);
		$display("abort done");
	endtask : test_abort
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		test_unipolar();
		test_bipolar();
		test_abort();
		wrap_up();
	end
endmodule : test_sar_adc_conversion_control
